// file: startup_irq_defs.vh
// Purpose: constants for the start-up sequencer and interrupt handler
// Assumes: 100 MHz CLOCK, 8-bit register data, 16-bit register addresses
// Notes: cycle counts above 4096 are only defaults of top-level parameters
`ifndef STARTUP_IRQ_DEFS_VH
`define STARTUP_IRQ_DEFS_VH

`define CLK_PERIOD_NS 10
`define IRQ_PULSE_NS 1000
`define IRQ_PULSE_CYC (`IRQ_PULSE_NS / `CLK_PERIOD_NS)

`define MODE0_CYCLES 8203
`define MODE1_CYCLES 948390
`define MODE2_CYCLES 73744
`define MODE3_CYCLES 1013931
`define MODE4_CYCLES 9
`define MODE5_CYCLES 3339
`define CNT_W 20

`define DATA_MEM_FIRST 15'h0000
`define DATA_MEM_LAST 15'h33FF
`define TABLE_MEM_FIRST 15'h3400
`define TABLE_MEM_LAST 15'h7FFF

`define ADDR_RX_PENDING 16'h8000
`define ADDR_RX_LABEL_CH0 16'h8001
`define ADDR_RX_LABEL_CH7 16'h8008
`define ADDR_FAULT_PENDING 16'h800A
`define ADDR_RX_MASK 16'h8020
`define ADDR_FAIL_LOW 16'h8073
`define ADDR_FAIL_HIGH 16'h8074

`define FAULT_COPY_BIT 7
`define FAULT_CMP_BIT 6
`define FAULT_SUM_BIT 5
`define FAULT_RAM_BIT 4
`define FAULT_FLAG_BIT 3
`define FAULT_TXRDY_BIT 2

`define RX_MASK_RESET 8'h00

`endif

// file: sync2.v
// Purpose: two-flop synchroniser for a bundle of asynchronous levels
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter W = 1
) (
  input wire clk,
  input wire arst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: startup_and_interrupt_control.v
// Purpose: start-up sequencing after master reset and interrupt handling
// Assumes: external RAM port with one-cycle read latency; EEPROM engine outside
// Notes: register port is the internal side of the host SPI link
//
// What this block does
// - after init, raise ready, go idle: host access only, no bus traffic
// - run rising edge in idle enters active state and starts message processing
// - ready rises no sooner than a fixed per-mode number of clock cycles after reset release
// - modes 2,3 write incrementing pattern, verify, write complement, verify
// - ram check failure sets ram fail bit, raises fault irq, enters safe state
// - modes 0,1,2,3,5 clear data memory 0x0000 to 0x33FF
// - modes 0 to 3 also clear tables to 0x7FFF and default the rx pending, mask and label registers
// - auto-init copies eeprom into memory, then compare and checksum check
// - compare mismatch sets compare error, stores fail address, enters safe state
// - checksum failure sets checksum error, fault irq, enters safe state
// - host may read and write memory and registers after init in every mode
// - receive interrupt only when lookup bit for channel and label is one
// - flagged message sets channel pending bit and stores its label
// - unmasked pending set raises rx irq until acknowledge goes high
// - acknowledge held high gives roughly 1 us rx irq pulse
// - reading rx pending returns contents and clears it
// - rx mask one lets pending bit drive rx irq, zero blocks it
// - four fault bits are unmaskable, masks fixed at one
// - eeprom copy mismatch after programming sets copy error bit
// - fault irq asserted while any fault pending bit is set
// - fault pending bits: copy, compare, checksum, ram, fifo flag, tx ready
// - mode pins sampled only at master reset falling edge
// - master reset high halts everything and drives ready low
`timescale 1ns/1ps
`default_nettype none
`include "startup_irq_defs.vh"
module startup_and_interrupt_control #(
  parameter MODE0_CYCLES = `MODE0_CYCLES,
  parameter MODE1_CYCLES = `MODE1_CYCLES,
  parameter MODE2_CYCLES = `MODE2_CYCLES,
  parameter MODE3_CYCLES = `MODE3_CYCLES,
  parameter MODE5_CYCLES = `MODE5_CYCLES
) (
  input wire CLOCK,
  input wire ARST_N,
  input wire MASTER_RESET_IN,
  input wire [2:0] STARTUP_SELECT_PINS,
  input wire RUN_IN,
  input wire RX_IRQ_ACK_IN,
  input wire [15:0] REG_ADDR,
  input wire REG_RD,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  output reg [14:0] MEM_ADDR,
  output reg MEM_WE,
  output reg MEM_RE,
  output reg [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA,
  output reg AUTOINIT_START,
  input wire AUTOINIT_DONE,
  input wire AUTOINIT_CMP_ERR,
  input wire AUTOINIT_SUM_ERR,
  input wire [14:0] AUTOINIT_FAIL_ADDR,
  input wire EEPROM_COPY_MISMATCH,
  input wire RX_MSG_VALID,
  input wire [2:0] RX_MSG_CH,
  input wire [7:0] RX_MSG_LABEL,
  input wire RX_LUT_HIT,
  input wire RX_FIFO_FLAG_ANY,
  input wire HOST_TX_READY_EVT,
  output reg READY,
  output reg BUS_ACTIVE,
  output reg SAFE_STATE,
  output reg HOST_ACCESS_OK,
  output reg RX_IRQ_OUT,
  output reg FAULT_IRQ_OUT
);
  localparam S_RST = 3'h0;
  localparam S_SWEEP = 3'h1;
  localparam S_AUTO = 3'h2;
  localparam S_WAIT = 3'h3;
  localparam S_IDLE = 3'h4;
  localparam S_ACTIVE = 3'h5;
  localparam S_SAFE = 3'h6;

  localparam P_PAT_W = 3'h0;
  localparam P_PAT_V = 3'h1;
  localparam P_CMP_W = 3'h2;
  localparam P_CMP_V = 3'h3;
  localparam P_CLR_D = 3'h4;
  localparam P_CLR_T = 3'h5;

  localparam integer MODE4_FULL = `MODE4_CYCLES;
  localparam integer PULSE_FULL = `IRQ_PULSE_CYC;
  localparam [`CNT_W-1:0] T_MODE0 = MODE0_CYCLES[`CNT_W-1:0];
  localparam [`CNT_W-1:0] T_MODE1 = MODE1_CYCLES[`CNT_W-1:0];
  localparam [`CNT_W-1:0] T_MODE2 = MODE2_CYCLES[`CNT_W-1:0];
  localparam [`CNT_W-1:0] T_MODE3 = MODE3_CYCLES[`CNT_W-1:0];
  localparam [`CNT_W-1:0] T_MODE4 = MODE4_FULL[`CNT_W-1:0];
  localparam [`CNT_W-1:0] T_MODE5 = MODE5_CYCLES[`CNT_W-1:0];
  localparam [6:0] PULSE_CYC = PULSE_FULL[6:0];

  wire master_reset_in_s;
  wire [2:0] mode_s;
  wire run_s;
  wire ack_s;

  sync2 #(.W(6)) u_sync (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .d({MASTER_RESET_IN, STARTUP_SELECT_PINS, RUN_IN, RX_IRQ_ACK_IN}),
    .q({master_reset_in_s, mode_s, run_s, ack_s})
  );

  reg master_reset_in_q_r;
  reg run_q_r;
  reg ack_q_r;
  reg [2:0] state_r;
  reg [2:0] phase_r;
  reg [2:0] mode_r;
  reg [14:0] addr_r;
  reg [`CNT_W-1:0] cnt_r;
  reg chk_vld_r;
  reg [7:0] chk_exp_r;
  reg chk_vld2_r;
  reg [7:0] chk_exp2_r;
  reg reg_default_r;
  reg [7:0] pend_r;
  reg [7:0] mask_r;
  reg [7:0] label_r [0:7];
  reg [3:0] fault_r;
  reg [14:0] fail_addr_r;
  reg [6:0] pulse_r;
  reg [7:0] pend_nxt;
  reg [7:0] pend_set;
  reg [7:0] rdata_nxt;
  reg [`CNT_W-1:0] target;
  reg [14:0] last_addr;
  reg is_write;
  reg [7:0] wdata;
  integer i;

  wire master_reset_in_fall = master_reset_in_q_r & ~master_reset_in_s;
  wire run_rise = run_s & ~run_q_r;
  wire ack_rise = ack_s & ~ack_q_r;
  wire rd_pend = REG_RD && (REG_ADDR == `ADDR_RX_PENDING);
  // ram data shows up the cycle after the ram has seen the read strobe
  wire ram_bad = chk_vld2_r && (MEM_RDATA != chk_exp2_r);
  // bits 3 and 2 are live levels from the fifo and transmitter logic
  wire [7:0] fault_view = {fault_r, RX_FIFO_FLAG_ANY, HOST_TX_READY_EVT, 2'b00};
  wire has_autoinit = mode_r[0];
  wire sweep_last = (addr_r == last_addr);

  always @* begin
    case (mode_r)
      3'h0: target = T_MODE0;
      3'h1: target = T_MODE1;
      3'h2: target = T_MODE2;
      3'h3: target = T_MODE3;
      3'h5: target = T_MODE5;
      default: target = T_MODE4;
    endcase
  end

  always @* begin
    is_write = 1'b1;
    wdata = 8'h00;
    last_addr = `DATA_MEM_LAST;
    case (phase_r)
      P_PAT_W: begin
        wdata = addr_r[7:0];
        last_addr = `TABLE_MEM_LAST;
      end
      P_PAT_V: begin
        is_write = 1'b0;
        last_addr = `TABLE_MEM_LAST;
      end
      P_CMP_W: begin
        wdata = ~addr_r[7:0];
        last_addr = `TABLE_MEM_LAST;
      end
      P_CMP_V: begin
        is_write = 1'b0;
        last_addr = `TABLE_MEM_LAST;
      end
      P_CLR_T: last_addr = `TABLE_MEM_LAST;
      default: last_addr = `DATA_MEM_LAST;
    endcase
  end

  // sequencer: reset, memory sweeps, auto-init, timing wait, idle/active/safe
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      master_reset_in_q_r <= 1'b0;
      run_q_r <= 1'b0;
      state_r <= S_RST;
      phase_r <= P_CLR_D;
      mode_r <= 3'h0;
      addr_r <= 15'h0000;
      cnt_r <= {`CNT_W{1'b0}};
      chk_vld_r <= 1'b0;
      chk_exp_r <= 8'h00;
      chk_vld2_r <= 1'b0;
      chk_exp2_r <= 8'h00;
      reg_default_r <= 1'b0;
      MEM_ADDR <= 15'h0000;
      MEM_WE <= 1'b0;
      MEM_RE <= 1'b0;
      MEM_WDATA <= 8'h00;
      AUTOINIT_START <= 1'b0;
      fault_r <= 4'h0;
      fail_addr_r <= 15'h0000;
      READY <= 1'b0;
      BUS_ACTIVE <= 1'b0;
      SAFE_STATE <= 1'b0;
      HOST_ACCESS_OK <= 1'b0;
    end else begin
      master_reset_in_q_r <= master_reset_in_s;
      run_q_r <= run_s;
      MEM_WE <= 1'b0;
      MEM_RE <= 1'b0;
      AUTOINIT_START <= 1'b0;
      reg_default_r <= 1'b0;
      chk_vld_r <= 1'b0;
      chk_vld2_r <= chk_vld_r;
      chk_exp2_r <= chk_exp_r;
      if (cnt_r != {`CNT_W{1'b1}})
        cnt_r <= cnt_r + {{(`CNT_W-1){1'b0}}, 1'b1};
      if (EEPROM_COPY_MISMATCH)
        fault_r[`FAULT_COPY_BIT-4] <= 1'b1;
      if (master_reset_in_s) begin
        // halts every phase at once; the fault record starts over
        state_r <= S_RST;
        READY <= 1'b0;
        BUS_ACTIVE <= 1'b0;
        SAFE_STATE <= 1'b0;
        HOST_ACCESS_OK <= 1'b0;
        fault_r <= 4'h0;
      end else begin
        case (state_r)
          S_RST: begin
            if (master_reset_in_fall) begin
              mode_r <= mode_s;
              cnt_r <= {`CNT_W{1'b0}};
              addr_r <= 15'h0000;
              state_r <= S_SWEEP;
              if (mode_s == 3'h2 || mode_s == 3'h3)
                phase_r <= P_PAT_W;
              else if (mode_s == 3'h4 || mode_s[2:1] == 2'b11)
                state_r <= S_WAIT;
              else
                phase_r <= P_CLR_D;
            end
          end
          S_SWEEP: begin
            MEM_ADDR <= addr_r;
            MEM_WDATA <= wdata;
            MEM_WE <= is_write;
            MEM_RE <= ~is_write;
            chk_vld_r <= ~is_write;
            chk_exp_r <= (phase_r == P_PAT_V) ? addr_r[7:0] : ~addr_r[7:0];
            if (sweep_last) begin
              addr_r <= (phase_r == P_CMP_V) ? 15'h0000 : `TABLE_MEM_FIRST;
              if (phase_r == P_CMP_V)
                phase_r <= P_CLR_D;
              else if (phase_r == P_CLR_D && mode_r[2])
                state_r <= has_autoinit ? S_AUTO : S_WAIT;
              else if (phase_r == P_CLR_D)
                phase_r <= P_CLR_T;
              else if (phase_r == P_CLR_T) begin
                reg_default_r <= 1'b1;
                state_r <= has_autoinit ? S_AUTO : S_WAIT;
              end else begin
                phase_r <= phase_r + 3'h1;
                addr_r <= 15'h0000;
              end
              if (state_r == S_SWEEP && (phase_r == P_CLR_D && mode_r[2] ||
                  phase_r == P_CLR_T) && has_autoinit)
                AUTOINIT_START <= 1'b1;
            end else begin
              addr_r <= addr_r + 15'h0001;
            end
          end
          S_AUTO: begin
            if (AUTOINIT_DONE) begin
              if (AUTOINIT_CMP_ERR) begin
                fault_r[`FAULT_CMP_BIT-4] <= 1'b1;
                fail_addr_r <= AUTOINIT_FAIL_ADDR;
                state_r <= S_SAFE;
              end else if (AUTOINIT_SUM_ERR) begin
                fault_r[`FAULT_SUM_BIT-4] <= 1'b1;
                state_r <= S_SAFE;
              end else begin
                state_r <= S_WAIT;
              end
            end
          end
          S_WAIT: begin
            // ready never comes early even if the work ends early
            if (cnt_r >= target) begin
              state_r <= S_IDLE;
              READY <= 1'b1;
              HOST_ACCESS_OK <= 1'b1;
            end
          end
          S_IDLE: begin
            if (run_rise) begin
              state_r <= S_ACTIVE;
              BUS_ACTIVE <= 1'b1;
            end
          end
          S_ACTIVE: BUS_ACTIVE <= 1'b1;
          S_SAFE: begin
            SAFE_STATE <= 1'b1;
            HOST_ACCESS_OK <= 1'b1;
          end
          default: state_r <= S_RST;
        endcase
        // a late verify result still fails the check after the sweep moved on
        if (ram_bad) begin
          fault_r[`FAULT_RAM_BIT-4] <= 1'b1;
          state_r <= S_SAFE;
          MEM_WE <= 1'b0;
          MEM_RE <= 1'b0;
          AUTOINIT_START <= 1'b0;
        end
      end
    end
  end

  // receive interrupt capture, only counted while the bus is running
  always @* begin
    pend_set = 8'h00;
    if (RX_MSG_VALID && RX_LUT_HIT && BUS_ACTIVE)
      pend_set[RX_MSG_CH] = 1'b1;
    pend_nxt = (rd_pend ? 8'h00 : pend_r) | pend_set;
  end

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_r <= 8'h00;
      mask_r <= `RX_MASK_RESET;
      for (i = 0; i < 8; i = i + 1)
        label_r[i] <= 8'h00;
    end else if (reg_default_r) begin
      pend_r <= 8'h00;
      mask_r <= `RX_MASK_RESET;
      for (i = 0; i < 8; i = i + 1)
        label_r[i] <= 8'h00;
    end else begin
      pend_r <= pend_nxt;
      if (|pend_set)
        label_r[RX_MSG_CH] <= RX_MSG_LABEL;
      if (REG_WR && REG_ADDR == `ADDR_RX_MASK)
        mask_r <= REG_WDATA;
    end
  end

  // rx irq: ack edge clears; a held-high ack ends it after the pulse time
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q_r <= 1'b0;
      pulse_r <= 7'h00;
      RX_IRQ_OUT <= 1'b0;
    end else begin
      ack_q_r <= ack_s;
      if (pulse_r != 7'h00)
        pulse_r <= pulse_r - 7'h01;
      if (|(pend_set & mask_r)) begin
        RX_IRQ_OUT <= 1'b1;
        pulse_r <= PULSE_CYC;
      end else if (ack_rise || (ack_s && pulse_r <= 7'h01)) begin
        RX_IRQ_OUT <= 1'b0;
      end
    end
  end

  // fault irq: no mask exists for the four fault bits
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N)
      FAULT_IRQ_OUT <= 1'b0;
    else
      FAULT_IRQ_OUT <= |fault_view;
  end

  always @* begin
    rdata_nxt = 8'h00;
    if (REG_ADDR == `ADDR_RX_PENDING)
      rdata_nxt = pend_r;
    else if (REG_ADDR >= `ADDR_RX_LABEL_CH0 && REG_ADDR <= `ADDR_RX_LABEL_CH7)
      rdata_nxt = label_r[REG_ADDR[2:0] - 3'h1];
    else if (REG_ADDR == `ADDR_FAULT_PENDING)
      rdata_nxt = fault_view;
    else if (REG_ADDR == `ADDR_RX_MASK)
      rdata_nxt = mask_r;
    else if (REG_ADDR == `ADDR_FAIL_LOW)
      rdata_nxt = fail_addr_r[7:0];
    else if (REG_ADDR == `ADDR_FAIL_HIGH)
      rdata_nxt = {1'b0, fail_addr_r[14:8]};
  end

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
      REG_RDATA <= rdata_nxt;
  end
endmodule
`default_nettype wire

// file: startup_irq_monitor.sv
// Purpose: port-level checks for start-up states and interrupt outputs
// Assumes: single CLOCK domain, ARST_N async active low
// Notes: sees top ports only; register contents are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module startup_irq_monitor (
  input wire CLOCK,
  input wire ARST_N,
  input wire MASTER_RESET_IN,
  input wire RUN_IN,
  input wire RX_IRQ_ACK_IN,
  input wire RX_MSG_VALID,
  input wire RX_LUT_HIT,
  input wire RX_FIFO_FLAG_ANY,
  input wire AUTOINIT_DONE,
  input wire AUTOINIT_CMP_ERR,
  input wire AUTOINIT_SUM_ERR,
  input wire READY,
  input wire BUS_ACTIVE,
  input wire SAFE_STATE,
  input wire HOST_ACCESS_OK,
  input wire RX_IRQ_OUT,
  input wire FAULT_IRQ_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  logic [7:0] hi_cnt;
  // held-ack pulse length, restarted by every new message
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) hi_cnt <= 8'h00;
    else if (!RX_IRQ_OUT || !RX_IRQ_ACK_IN || RX_MSG_VALID) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
  end
  sequence run_rise;
    READY && !SAFE_STATE && !MASTER_RESET_IN && $rose(RUN_IN);
  endsequence
  sequence ack_rise;
    $rose(RX_IRQ_ACK_IN) ##1 (!RX_MSG_VALID) [*4];
  endsequence
  safe_state_a: assert property (SAFE_STATE |-> !READY && HOST_ACCESS_OK)
    else $error("safe state with ready or without host access");
  active_ready_a: assert property (BUS_ACTIVE |-> READY && !SAFE_STATE)
    else $error("bus active outside idle path");
  run_start_a: assert property (run_rise |-> ##[1:4] BUS_ACTIVE)
    else $error("run edge did not start bus operation");
  mreset_halt_a: assert property (MASTER_RESET_IN [*5] |-> !READY && !BUS_ACTIVE)
    else $error("ready stayed high under master reset");
  rx_cause_a: assert property ($rose(RX_IRQ_OUT) |-> $past(RX_MSG_VALID && RX_LUT_HIT && BUS_ACTIVE))
    else $error("rx irq rose without a flagged message");
  ack_clear_a: assert property (ack_rise |=> !RX_IRQ_OUT)
    else $error("rx irq not cleared by acknowledge");
  pulse_len_a: assert property (hi_cnt <= 8'h68)
    else $error("rx irq pulse too long with ack held");
  fault_live_a: assert property (RX_FIFO_FLAG_ANY [*3] |-> FAULT_IRQ_OUT)
    else $error("fault irq missing while fifo flag set");
  init_fail_a: assert property (AUTOINIT_DONE && (AUTOINIT_CMP_ERR || AUTOINIT_SUM_ERR)
    |-> ##[1:3] (SAFE_STATE && FAULT_IRQ_OUT))
    else $error("auto-init error did not give safe state");
endmodule
bind startup_and_interrupt_control startup_irq_monitor u_mon (.CLOCK(CLOCK), .ARST_N(ARST_N),
  .MASTER_RESET_IN(MASTER_RESET_IN), .RUN_IN(RUN_IN), .RX_IRQ_ACK_IN(RX_IRQ_ACK_IN),
  .RX_MSG_VALID(RX_MSG_VALID), .RX_LUT_HIT(RX_LUT_HIT), .RX_FIFO_FLAG_ANY(RX_FIFO_FLAG_ANY),
  .AUTOINIT_DONE(AUTOINIT_DONE), .AUTOINIT_CMP_ERR(AUTOINIT_CMP_ERR),
  .AUTOINIT_SUM_ERR(AUTOINIT_SUM_ERR), .READY(READY), .BUS_ACTIVE(BUS_ACTIVE),
  .SAFE_STATE(SAFE_STATE), .HOST_ACCESS_OK(HOST_ACCESS_OK), .RX_IRQ_OUT(RX_IRQ_OUT),
  .FAULT_IRQ_OUT(FAULT_IRQ_OUT));
`default_nettype wire

// file: mem_side_model.sv
// Purpose: RAM and eeprom engine standing behind the memory port
// Assumes: one-cycle read latency, done pulse 20 cycles after start
// Notes: idle read data toggles so a stale value never passes
`timescale 1ns/1ps
`default_nettype none
module mem_side_model (
  input wire CLOCK,
  input wire MASTER_RESET_IN,
  input wire [14:0] MEM_ADDR,
  input wire MEM_WE,
  input wire MEM_RE,
  input wire [7:0] MEM_WDATA,
  output var logic [7:0] MEM_RDATA,
  input wire AUTOINIT_START,
  output var logic AUTOINIT_DONE,
  output wire AUTOINIT_CMP_ERR,
  output wire AUTOINIT_SUM_ERR,
  output wire [14:0] AUTOINIT_FAIL_ADDR,
  input wire [1:0] err_kind,
  output var logic [15:0] n_wr,
  output var logic [14:0] max_addr,
  output var logic bad_wr
);
  logic [7:0] mem [0:32767];
  logic [5:0] dly;
  assign AUTOINIT_CMP_ERR = (err_kind == 2'h1);
  assign AUTOINIT_SUM_ERR = (err_kind == 2'h2);
  assign AUTOINIT_FAIL_ADDR = 15'h1234;
  initial begin
    MEM_RDATA = 8'h00;
    AUTOINIT_DONE = 1'b0;
    dly = 6'h00;
  end
  always @(posedge CLOCK) begin
    AUTOINIT_DONE <= 1'b0;
    MEM_RDATA <= MEM_RE ? mem[MEM_ADDR] : ~MEM_RDATA;
    if (MEM_WE) begin
      mem[MEM_ADDR] <= MEM_WDATA;
      n_wr <= n_wr + 16'h0001;
      if (MEM_ADDR > max_addr) max_addr <= MEM_ADDR;
      if (MEM_WDATA !== 8'h00) bad_wr <= 1'b1;
    end
    if (AUTOINIT_START) dly <= 6'h14;
    else if (dly != 6'h00) begin
      dly <= dly - 6'h01;
      AUTOINIT_DONE <= (dly == 6'h01);
    end
    if (MASTER_RESET_IN) begin
      n_wr <= 16'h0000;
      max_addr <= 15'h0000;
      bad_wr <= 1'b0;
      dly <= 6'h00;
    end
  end
endmodule
`default_nettype wire

// file: startup_and_interrupt_control_test.sv
// Purpose: directed register-level tests of start-up and interrupts
// Assumes: mode 5 count raised to 14000, just above its data clear
// Notes: modes 2 and 3 need four full RAM sweeps and are not run here
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module startup_and_interrupt_control_test;
  logic CLOCK = 0, ARST_N = 0, MASTER_RESET_IN = 0, RUN_IN = 0, RX_IRQ_ACK_IN = 0;
  logic [2:0] STARTUP_SELECT_PINS = 0, RX_MSG_CH = 0;
  logic [15:0] REG_ADDR = 0, n_wr;
  logic REG_RD = 0, REG_WR = 0, RX_MSG_VALID = 0, RX_LUT_HIT = 0, FLAG = 0, TXR = 0, CPY = 0;
  logic [7:0] REG_WDATA = 0, RX_MSG_LABEL = 0, REG_RDATA, MEM_WDATA, MEM_RDATA, d;
  logic [14:0] MEM_ADDR, FAIL_ADDR, max_addr;
  logic MEM_WE, MEM_RE, START, DONE, CMP, SUM, READY, BUS_ACTIVE, SAFE_STATE, RX_IRQ_OUT;
  logic FAULT_IRQ_OUT, bad_wr;
  logic [1:0] err_kind = 0;
  int n_errors = 0, total_checks = 0, n;
  startup_and_interrupt_control #(.MODE5_CYCLES(14000)) DUT (.CLOCK(CLOCK), .ARST_N(ARST_N),
    .MASTER_RESET_IN(MASTER_RESET_IN), .STARTUP_SELECT_PINS(STARTUP_SELECT_PINS),
    .RUN_IN(RUN_IN), .RX_IRQ_ACK_IN(RX_IRQ_ACK_IN), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .MEM_ADDR(MEM_ADDR),
    .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .AUTOINIT_START(START), .AUTOINIT_DONE(DONE), .AUTOINIT_CMP_ERR(CMP),
    .AUTOINIT_SUM_ERR(SUM), .AUTOINIT_FAIL_ADDR(FAIL_ADDR), .EEPROM_COPY_MISMATCH(CPY),
    .RX_MSG_VALID(RX_MSG_VALID), .RX_MSG_CH(RX_MSG_CH), .RX_MSG_LABEL(RX_MSG_LABEL),
    .RX_LUT_HIT(RX_LUT_HIT), .RX_FIFO_FLAG_ANY(FLAG), .HOST_TX_READY_EVT(TXR),
    .READY(READY), .BUS_ACTIVE(BUS_ACTIVE), .SAFE_STATE(SAFE_STATE), .HOST_ACCESS_OK(),
    .RX_IRQ_OUT(RX_IRQ_OUT), .FAULT_IRQ_OUT(FAULT_IRQ_OUT));
  mem_side_model u_far (.CLOCK(CLOCK), .MASTER_RESET_IN(MASTER_RESET_IN), .MEM_ADDR(MEM_ADDR),
    .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .AUTOINIT_START(START), .AUTOINIT_DONE(DONE), .AUTOINIT_CMP_ERR(CMP),
    .AUTOINIT_SUM_ERR(SUM), .AUTOINIT_FAIL_ADDR(FAIL_ADDR), .err_kind(err_kind),
    .n_wr(n_wr), .max_addr(max_addr), .bad_wr(bad_wr));
  initial begin
    forever #5 CLOCK = ~CLOCK;
  end
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge CLOCK); REG_ADDR <= a; REG_RD <= 1;
    @(posedge CLOCK); REG_RD <= 0;
    @(posedge CLOCK); #1 v = REG_RDATA;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge CLOCK); REG_ADDR <= a; REG_WDATA <= v; REG_WR <= 1;
    @(posedge CLOCK); REG_WR <= 0;
  endtask
  task automatic msg(input logic [2:0] ch, input logic [7:0] lab, input logic hit);
    @(posedge CLOCK); RX_MSG_VALID <= 1; RX_MSG_CH <= ch; RX_MSG_LABEL <= lab; RX_LUT_HIT <= hit;
    @(posedge CLOCK); RX_MSG_VALID <= 0;
    @(posedge CLOCK); #1;
  endtask
  // mode pins are changed only while master reset is high
  task automatic boot(input logic [2:0] m, input logic [1:0] k);
    @(posedge CLOCK); STARTUP_SELECT_PINS <= m; err_kind <= k; MASTER_RESET_IN <= 1;
    repeat (6) @(posedge CLOCK);
    MASTER_RESET_IN <= 0;
    n = 0;
    while (!READY && !SAFE_STATE && n < 40000) begin
      @(posedge CLOCK); #1 n++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #900_000 n_errors++;
    print_verdict;
  end
  initial begin
    logic [7:0] exp_f [3] = '{8'h00, 8'h40, 8'h20};
    repeat (5) @(posedge CLOCK);
    ARST_N <= 1;
    for (int a = 0; a < 9; a++) begin
      rd(16'h8000 + a[15:0], d); `CHK("reset value", 8'h00, d)
    end
    rd(16'h800A, d); `CHK("fault reset", 8'h00, d)
    rd(16'h8020, d); `CHK("mask reset", 8'h00, d)
    for (int k = 0; k < 3; k++) begin
      boot(3'h5, k[1:0]);
      `CHK("ready", k == 0, READY)
      `CHK("safe", k != 0, SAFE_STATE)
      `CHK("fault irq", k != 0, FAULT_IRQ_OUT)
      rd(16'h800A, d); `CHK("fault bits", exp_f[k], d)
      `CHK("clear count", 16'h3400, n_wr)
      `CHK("clear top", 15'h33FF, max_addr)
      `CHK("clear data", 1'b0, bad_wr)
      if (k == 0) `CHK("mode5 time", 1'b1, n >= 14000 && n <= 14010)
      if (k == 1) begin
        rd(16'h8073, d); `CHK("fail low", 8'h34, d)
        rd(16'h8074, d); `CHK("fail high", 8'h12, d)
      end
      $display("mode5 test %0d done", k);
    end
    boot(3'h4, 2'h0);
    `CHK("mode4 time", 1'b1, n >= 9 && n <= 15)
    `CHK("mode4 no clear", 16'h0000, n_wr)
    msg(3'h1, 8'h11, 1);
    rd(16'h8000, d); `CHK("idle ignores rx", 8'h00, d)
    @(posedge CLOCK); RUN_IN <= 1;
    repeat (6) @(posedge CLOCK);
    #1 `CHK("active", 1'b1, BUS_ACTIVE)
    wr(16'h8020, 8'h80); rd(16'h8020, d); `CHK("mask", 8'h80, d)
    msg(3'h7, 8'hD4, 1); `CHK("rx irq", 1'b1, RX_IRQ_OUT)
    rd(16'h8008, d); `CHK("label7", 8'hD4, d)
    rd(16'h8000, d); `CHK("pending", 8'h80, d)
    rd(16'h8000, d); `CHK("pending cleared", 8'h00, d)
    @(posedge CLOCK); RX_IRQ_ACK_IN <= 1;
    repeat (5) @(posedge CLOCK);
    #1 `CHK("ack clears", 1'b0, RX_IRQ_OUT)
    msg(3'h7, 8'h3C, 1);
    n = 2;
    while (RX_IRQ_OUT && n < 300) begin
      @(posedge CLOCK); #1 n++;
    end
    `CHK("pulse length", 1'b1, n >= 96 && n <= 104)
    @(posedge CLOCK); RX_IRQ_ACK_IN <= 0;
    msg(3'h3, 8'h55, 0); `CHK("no lookup hit", 1'b0, RX_IRQ_OUT)
    msg(3'h2, 8'h66, 1); `CHK("masked", 1'b0, RX_IRQ_OUT)
    rd(16'h8003, d); `CHK("label2", 8'h66, d)
    wr(16'h8000, 8'hFF);
    rd(16'h8000, d); `CHK("pending ch2 ch7", 8'h84, d)
    rd(16'h8050, d); `CHK("unmapped", 8'h00, d)
    $display("rx test done");
    @(posedge CLOCK); FLAG <= 1;
    repeat (5) @(posedge CLOCK);
    rd(16'h800A, d); `CHK("flag bit", 8'h08, d)
    `CHK("flag irq", 1'b1, FAULT_IRQ_OUT)
    @(posedge CLOCK); FLAG <= 0; TXR <= 1; CPY <= 1;
    @(posedge CLOCK); CPY <= 0;
    repeat (5) @(posedge CLOCK);
    rd(16'h800A, d); `CHK("copy and txrdy", 8'h84, d)
    @(posedge CLOCK); MASTER_RESET_IN <= 1; TXR <= 0;
    repeat (6) @(posedge CLOCK);
    #1 `CHK("halt", 2'b00, {READY, BUS_ACTIVE})
    $display("fault test done");
    boot(3'h0, 2'h0);
    `CHK("mode0 ready", 1'b1, READY)
    `CHK("mode0 clear count", 16'h8000, n_wr)
    `CHK("mode0 clear top", 15'h7FFF, max_addr)
    `CHK("mode0 clear data", 1'b0, bad_wr)
    rd(16'h8020, d); `CHK("mask default", 8'h00, d)
    rd(16'h8008, d); `CHK("label default", 8'h00, d)
    $display("mode0 test done");
    print_verdict;
  end
endmodule
`default_nettype wire
